// [logic/bus_ev_if.sv]
`timescale 1ns/1ps
interface bus_ev_if;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic sda;
    modport src (output scl_rise, scl_fall, start, stop, sda);
    modport dst (input  scl_rise, scl_fall, start, stop, sda);
endinterface

// [logic/eeprom_pkg.sv]
package eeprom_pkg;
    // array geometry
    localparam int ADDR_W      = 12;
    localparam int PAGE_W      = 5;
    localparam int DATA_W      = 8;
    // bus framing
    localparam logic [6:0] DEV_ID    = 7'h50;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [7:0] MEM_RESET = 8'hff;
    localparam logic [2:0] PIN_IDLE  = 3'h7;

    typedef enum {ST_IDLE, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK, ST_WAIT_STOP} bus_state_e;
    typedef enum {K_DEV, K_WAH, K_WAL, K_DATA} rx_kind_e;
endpackage

// [logic/pin_sync.sv]
`timescale 1ns/1ps
module pin_sync (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    // bus pins
    input  wire logic scl_in,
    input  wire logic sda_in,
    // decoded events
    bus_ev_if.src     ev
);
    import eeprom_pkg::*;

    // stage 0 feeds only stage 1; stage 2 is the previous synced value
    logic [2:0] scl_q_r;
    logic [2:0] sda_q_r;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            scl_q_r <= PIN_IDLE;
            sda_q_r <= PIN_IDLE;
        end else begin
            scl_q_r <= {scl_q_r[1:0], scl_in};
            sda_q_r <= {sda_q_r[1:0], sda_in};
        end
    end

    assign ev.scl_rise = scl_q_r[1] & ~scl_q_r[2];
    assign ev.scl_fall = ~scl_q_r[1] & scl_q_r[2];
    assign ev.start    = scl_q_r[1] & scl_q_r[2] & sda_q_r[2] & ~sda_q_r[1];
    assign ev.stop     = scl_q_r[1] & scl_q_r[2] & ~sda_q_r[2] & sda_q_r[1];
    assign ev.sda      = sda_q_r[1];

    a_start_sda_fall: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ev.start |-> $past(sda_q_r[1]) && !sda_q_r[1] && scl_q_r[1]) // RULE11
        else $error("start without sda falling under high scl");
endmodule // pin_sync

// [logic/serial_eeprom.sv]
`timescale 1ns/1ps
// What this block does
// (RULE1) a page write holds up to 32 bytes, all stored after the command
// (RULE2) each written byte steps only the five page offset bits, wrapping
// (RULE3) the seven upper address bits stay fixed during a page write
// (RULE4) after a read ending at n, a current read returns word n+1
// (RULE5) after a write ending at n, a current read returns word n
// (RULE6) each low acknowledge without stop brings the next word out
// (RULE7) no acknowledge: stop sending, release data, wait for stop
// (RULE8) the master ends a read with a high acknowledge then a stop
// (RULE9) random read returns the word at the address just supplied
// (RULE10) streaming continues from both current and random read starts
// (RULE11) slave address is 1010, 000, then direction bit, 1 means read
// (RULE12) acknowledge slave address and every write byte with low data
// (RULE13) the nonvolatile write starts only on the stop ending a write
// (RULE14) a write not ended by stop is discarded, memory unchanged
// (RULE15) random read: write address, word address, repeated start, read address
// (RULE16) sequential read steps the full address counter and wraps to zero
module serial_eeprom #(
    parameter int ADDR_W = eeprom_pkg::ADDR_W,
    parameter int PAGE_W = eeprom_pkg::PAGE_W
) (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    // two-wire bus
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      sda_out_out,
    output logic      sda_oe_out,
    // array write strobe
    output logic      nv_write_start_out
);
    import eeprom_pkg::*;

    localparam int WORDS      = 1 << ADDR_W;
    localparam int PAGE_BYTES = 1 << PAGE_W;

    if (ADDR_W < 9 || ADDR_W > 16 || PAGE_W < 1 || PAGE_W >= 8) begin : g_bad_geometry
        $error("serial_eeprom: unsupported address or page width");
    end

    bus_ev_if ev ();

    pin_sync u_sync (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .scl_in   (scl_in),
        .sda_in   (sda_in),
        .ev       (ev.src)
    );

    bus_state_e              state_r;
    rx_kind_e                kind_r;
    logic [3:0]              cnt_r;
    logic [DATA_W-1:0]       rx_sh_r;
    logic [DATA_W-1:0]       tx_sh_r;
    logic [ADDR_W-1:0]       addr_r;
    logic [ADDR_W-1:0]       last_wr_r;
    logic [PAGE_BYTES-1:0]   valid_r;
    logic [DATA_W-1:0]       buf_r [PAGE_BYTES];
    logic [DATA_W-1:0]       mem_r [WORDS];
    logic                    oe_r;
    logic                    tx_next_r;
    logic                    acked_r;
    logic                    wr_start_r;
    logic                    sda_o_r;

    // decode
    wire logic              byte_end = ev.scl_fall && cnt_r == BYTE_BITS;
    wire logic              dev_hit  = rx_sh_r[7:1] == DEV_ID;
    wire logic              rx_done  = state_r == ST_RX && byte_end;
    wire logic              tx_done  = state_r == ST_TX && byte_end;
    wire logic              commit   = ev.stop && |valid_r;
    wire logic [DATA_W-1:0] rd_byte  = mem_r[addr_r];
    wire logic [PAGE_W-1:0] offs     = addr_r[PAGE_W-1:0];
    wire logic [ADDR_W-1:0] page_inc = {addr_r[ADDR_W-1:PAGE_W], PAGE_W'(offs + 1'b1)};
    // the enum is two-state, so it cannot be a net; a variable fed by an assign instead
    rx_kind_e               kind_nxt;
    assign kind_nxt = (kind_r == K_DEV) ? K_WAH :
                      (kind_r == K_WAH) ? K_WAL : K_DATA;

    // start and stop override any byte in progress
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_r   <= ST_IDLE;
            kind_r    <= K_DEV;
            cnt_r     <= '0;
            rx_sh_r   <= '0;
            tx_next_r <= 1'b0;
            acked_r   <= 1'b0;
        end else if (ev.start) begin
            state_r <= ST_RX;
            kind_r  <= K_DEV;
            cnt_r   <= '0;
        end else if (ev.stop) begin
            state_r <= ST_IDLE;
        end else begin
            unique case (state_r)
                ST_IDLE, ST_WAIT_STOP: begin
                end
                ST_RX: begin
                    if (ev.scl_rise) begin
                        rx_sh_r <= {rx_sh_r[6:0], ev.sda};
                        cnt_r   <= cnt_r + 4'h1;
                    end else if (byte_end) begin
                        if (kind_r == K_DEV && !dev_hit) begin
                            state_r <= ST_IDLE; // RULE11
                        end else begin
                            state_r   <= ST_RX_ACK;
                            tx_next_r <= kind_r == K_DEV && rx_sh_r[0]; // RULE11
                            kind_r    <= kind_nxt;
                        end
                    end
                end
                ST_RX_ACK: begin
                    if (ev.scl_fall) begin
                        cnt_r   <= '0;
                        state_r <= tx_next_r ? ST_TX : ST_RX;
                    end
                end
                ST_TX: begin
                    if (ev.scl_rise) begin
                        cnt_r <= cnt_r + 4'h1;
                    end else if (byte_end) begin
                        state_r <= ST_TX_ACK;
                    end
                end
                ST_TX_ACK: begin
                    if (ev.scl_rise) begin
                        acked_r <= !ev.sda;
                        if (ev.sda) begin
                            state_r <= ST_WAIT_STOP; // RULE7 RULE8
                        end
                    end else if (ev.scl_fall && acked_r) begin
                        state_r <= ST_TX; // RULE6 RULE10
                        cnt_r   <= '0;
                    end
                end
            endcase
        end
    end

    // open drain: the line is only ever pulled low
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            oe_r    <= 1'b0;
            tx_sh_r <= MEM_RESET;
        end else if (ev.start || ev.stop) begin
            oe_r <= 1'b0;
        end else if (rx_done && (kind_r != K_DEV || dev_hit)) begin
            oe_r <= 1'b1; // RULE12
        end else if (state_r == ST_RX_ACK && ev.scl_fall) begin
            oe_r <= tx_next_r && !rd_byte[7]; // RULE9
            if (tx_next_r) begin
                tx_sh_r <= rd_byte;
            end
        end else if (tx_done) begin
            oe_r <= 1'b0; // RULE7
        end else if (state_r == ST_TX && ev.scl_fall) begin
            tx_sh_r <= {tx_sh_r[6:0], 1'b1};
            oe_r    <= !tx_sh_r[6];
        end else if (state_r == ST_TX_ACK && ev.scl_fall && acked_r) begin
            tx_sh_r <= rd_byte; // RULE6
            oe_r    <= !rd_byte[7];
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            addr_r    <= '0;
            last_wr_r <= '0;
        end else if (commit) begin
            addr_r <= last_wr_r; // RULE5
        end else if (rx_done) begin
            unique case (kind_r)
                K_DEV: begin
                end
                K_WAH: addr_r[ADDR_W-1:8] <= rx_sh_r[ADDR_W-9:0];
                K_WAL: addr_r[7:0] <= rx_sh_r;
                K_DATA: begin
                    last_wr_r <= addr_r;
                    addr_r    <= page_inc; // RULE2 RULE3
                end
            endcase
        end else if (tx_done) begin
            addr_r <= addr_r + 1'b1; // RULE4 RULE16
        end
    end

    // page buffer; a repeated start drops it, so only a stop can commit
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            valid_r <= '0;
            for (int i = 0; i < PAGE_BYTES; i++) begin
                buf_r[i] <= MEM_RESET;
            end
        end else if (ev.start || ev.stop) begin
            valid_r <= '0; // RULE14
        end else if (rx_done && kind_r == K_DATA) begin
            buf_r[offs]   <= rx_sh_r; // RULE1
            valid_r[offs] <= 1'b1;
        end
    end

    // array held in flops; written only from the valid entries of the page buffer
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < WORDS; i++) begin
                mem_r[i] <= MEM_RESET;
            end
        end else if (commit) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                if (valid_r[i]) begin
                    mem_r[{addr_r[ADDR_W-1:PAGE_W], PAGE_W'(i)}] <= buf_r[i]; // RULE1 RULE13
                end
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            wr_start_r <= 1'b0;
            sda_o_r    <= 1'b0;
        end else begin
            wr_start_r <= commit; // RULE13
            sda_o_r    <= 1'b0;
        end
    end

    assign sda_out_out        = sda_o_r;
    assign sda_oe_out         = oe_r;
    assign nv_write_start_out = wr_start_r;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    a_page_offset_step: assert property (rx_done && kind_r == K_DATA
        |=> addr_r[PAGE_W-1:0] == PAGE_W'($past(addr_r[PAGE_W-1:0]) + 1'b1)) // RULE2
        else $error("page offset did not step by one");
    a_page_upper_hold: assert property (rx_done && kind_r == K_DATA
        |=> addr_r[ADDR_W-1:PAGE_W] == $past(addr_r[ADDR_W-1:PAGE_W])) // RULE3
        else $error("page write left its page");
    a_read_counter_step: assert property (tx_done && !commit
        |=> addr_r == ADDR_W'($past(addr_r) + 1'b1)) // RULE4
        else $error("read did not advance the counter");
    a_write_counter_hold: assert property (commit |=> addr_r == $past(last_wr_r)) // RULE5
        else $error("counter not left at last written address");
    a_nack_release: assert property (state_r == ST_TX_ACK && ev.scl_rise && ev.sda
        && !ev.start && !ev.stop |=> state_r == ST_WAIT_STOP ##1 !oe_r) // RULE7
        else $error("no release after missing acknowledge");
    a_ack_next_bit: assert property (state_r == ST_TX_ACK && ev.scl_fall && acked_r
        && !ev.start && !ev.stop |=> state_r == ST_TX && oe_r == !$past(rd_byte[7])) // RULE6
        else $error("next word not driven after acknowledge");
    a_ack_drive: assert property (rx_done && !ev.start && !ev.stop
        && (kind_r != K_DEV || dev_hit) |=> oe_r && state_r == ST_RX_ACK) // RULE12
        else $error("byte not acknowledged");
    a_foreign_ignore: assert property (rx_done && kind_r == K_DEV && !dev_hit
        && !ev.start && !ev.stop |=> state_r == ST_IDLE && !oe_r) // RULE11
        else $error("foreign slave address answered");
    a_write_on_stop: assert property (wr_start_r |-> $past(ev.stop) && $past(|valid_r)) // RULE13
        else $error("array write not caused by stop");
    a_restart_discard: assert property (ev.start |=> valid_r == '0 ##1 !wr_start_r) // RULE14
        else $error("pending write survived a start");
endmodule // serial_eeprom

// [verif/host_master.sv]
`timescale 1ns/1ps
// behavioural bus master; a line it releases floats high through the pull-up
module host_master (
    // clock
    input  wire logic clk_in,
    // bus
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_low_out
);
    initial begin
        scl_out     = 1'b1;
        sda_low_out = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    // also serves as repeated start, since scl is low between tasks
    task automatic start();
        sda_low_out = 1'b0;
        tick(10);
        scl_out = 1'b1;
        tick(10);
        sda_low_out = 1'b1;
        tick(10);
        scl_out = 1'b0;
        tick(5);
    endtask

    task automatic stop();
        sda_low_out = 1'b1;
        tick(10);
        scl_out = 1'b1;
        tick(10);
        sda_low_out = 1'b0;
        tick(10);
    endtask

    // sample mid-high: the device moves data only a few clocks after scl falls
    task automatic bit_io(input logic b, output logic r);
        sda_low_out = ~b;
        tick(10);
        scl_out = 1'b1;
        tick(5);
        r = sda_in;
        tick(5);
        scl_out = 1'b0;
        tick(5);
    endtask

    task automatic byte_tx(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, ack);
    endtask

    task automatic byte_rx(output logic [7:0] d, input logic more);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(~more, r);
    endtask
endmodule // host_master

// [verif/tb.sv]
`timescale 1ns/1ps
module tb;
    import eeprom_pkg::*;
    logic       clk_in;
    logic       rst_n_in;
    logic       scl;
    logic       m_low;
    logic       sda_out;
    logic       sda_oe;
    logic       nv_start;
    wire        sda = (sda_oe ? sda_out : 1'b1) & ~m_low;
    logic [7:0] ref_mem [4096];
    int         err_total = 0;
    int         n_tests   = 0;
    int         nv_cnt    = 0;
    int         cyc       = 0;

    serial_eeprom dut_u (
        .clk_in             (clk_in),
        .rst_n_in           (rst_n_in),
        .scl_in             (scl),
        .sda_in             (sda),
        .sda_out_out        (sda_out),
        .sda_oe_out         (sda_oe),
        .nv_write_start_out (nv_start)
    );
    host_master m_u (.clk_in(clk_in), .sda_in(sda), .scl_out(scl), .sda_low_out(m_low));

    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end

    // about 110 bytes of traffic need near 25000 cycles
    always @(posedge clk_in) begin
        cyc++;
        if (nv_start === 1'b1) nv_cnt++;
        if (cyc == 60000) begin
            err_total++;
            close_out();
        end
    end

    task automatic close_out();
        $display("tests %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic send(input logic [7:0] d);
        logic a;
        m_u.byte_tx(d, a);
        check({7'h0, a}, 8'h00);
    endtask

    task automatic hdr(input logic [11:0] a);
        m_u.start();
        send({DEV_ID, 1'b0});
        send({4'h0, a[11:8]});
        send(a[7:0]);
    endtask

    // a is the expected counter when rnd is low
    task automatic rd(input logic [11:0] a, input int n, input logic rnd);
        logic [7:0] d;
        logic       r;
        if (rnd) hdr(a);
        m_u.start();
        send({DEV_ID, 1'b1});
        for (int i = 0; i < n; i++) begin
            m_u.byte_rx(d, i < n - 1);
            check(d, ref_mem[a + 12'(i)]);
        end
        m_u.bit_io(1'b1, r);
        check({7'h0, r}, 8'h01);
        m_u.stop();
    endtask

    task automatic wr(input logic [11:0] a, input int n, input logic [7:0] v);
        int c;
        c = nv_cnt;
        hdr(a);
        for (int i = 0; i < n; i++) begin
            send(v + 8'(i));
            ref_mem[{a[11:5], a[4:0] + 5'(i)}] = v + 8'(i);
        end
        m_u.stop();
        m_u.tick(4);
        check(8'(nv_cnt - c), 8'h01);
    endtask

    task automatic t_foreign();
        logic a;
        m_u.start();
        m_u.byte_tx(8'ha2, a);
        check({7'h0, a}, 8'h01);
        m_u.stop();
    endtask

    task automatic t_page();
        wr(12'h11e, 3, 8'h41);
        rd(12'h100, 1, 1'b0);
    endtask

    task automatic t_full();
        wr(12'h340, 32, 8'h80);
        rd(12'h340, 32, 1'b1);
    endtask

    task automatic t_rand();
        rd(12'h11e, 1, 1'b1);
        rd(12'h11f, 2, 1'b0);
    endtask

    // repeated start instead of stop must drop the byte
    task automatic t_abort();
        int c;
        c = nv_cnt;
        hdr(12'h200);
        send(8'h77);
        rd(12'h200, 1, 1'b1);
        check(8'(nv_cnt - c), 8'h00);
    endtask

    task automatic t_wrap();
        wr(12'h000, 1, 8'h3c);
        rd(12'hfff, 2, 1'b1);
    endtask

    initial begin
        rst_n_in = 1'b0;
        for (int i = 0; i < 4096; i++) ref_mem[i] = MEM_RESET;
        repeat (20) @(posedge clk_in);
        #1;
        rst_n_in = 1'b1;
        m_u.tick(4);
        t_foreign();
        t_page();
        t_full();
        t_rand();
        t_abort();
        t_wrap();
        close_out();
    end
endmodule // tb
